// file: include/intc_pkg.sv
// Purpose: Shared constants and types of the two-level interrupt controller
// Assumes: Eight sources, four of them pin edges and one a port change
// Notes:   Source indices below fix the meaning of every per-source vector
package intc_pkg;
  // ==========================================================
  // Source layout
  localparam int NUM_SRC  = 8;
  localparam int NUM_EXT  = 4;                // Edge pins, sources 0..3
  localparam int NUM_PORT = 4;                // Port change inputs
  localparam int SRC_PORT = 4;                // Port change source index
  // Sources gated by the peripheral enable in compatibility mode
  localparam logic [NUM_SRC-1:0] PERIPH_MASK = 8'hc0;
  // ==========================================================
  // Vector addresses
  localparam logic [15:0] VEC_HIGH = 16'h0008;
  localparam logic [15:0] VEC_LOW  = 16'h0018;
  // ==========================================================
  // Control word bit positions and reset values
  localparam int   BIT_GIE_HIGH   = 7;        // Global / high enable
  localparam int   BIT_GIE_LOW    = 6;        // Peripheral / low enable
  localparam logic GLOBAL_EN_RST  = 1'b0;
  localparam logic [NUM_SRC-1:0] FLAG_RST = 8'h00;
  localparam logic [15:0] VEC_RST = 16'h0000;
  localparam int   SYNC_STAGES    = 2;
  // ==========================================================
  // Service context
  typedef enum logic [1:0] {
    ST_RUN, ST_LOW, ST_HIGH, ST_HIGH_OVER_LOW
  } isr_state_type;
endpackage

// file: include/pin_event_if.sv
// Purpose: Carries pin edge and port change events to the controller core
// Assumes: Both ends run on core_clk
// Notes:   Events are single-cycle pulses, port change is a level
`timescale 1ns/10ps
`default_nettype none
interface pin_event_if;
  import intc_pkg::*;
  logic [NUM_EXT-1:0] extEdge;
  logic               portChange;
  modport producer (output extEdge, output portChange);
  modport consumer (input  extEdge, input  portChange);
endinterface
`default_nettype wire

// file: rtl/pin_event_detect.sv
// Purpose: Synchronise edge pins and port pins, detect selected events
// Assumes: Pins are asynchronous to core_clk
// Notes:   Detection is held off until the synchronisers hold real samples
`timescale 1ns/10ps
`default_nettype none
module pin_event_detect
  import intc_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic [NUM_EXT-1:0]  extPin,
  input  wire logic [NUM_EXT-1:0]  extEdgeSelect,
  input  wire logic [NUM_PORT-1:0] portPin,
  input  wire logic                portRead,
  pin_event_if.producer            ev
);
  // ==========================================================
  // State
  logic [NUM_EXT-1:0]     extMeta_r, extSync_r, extPrev_r;
  logic [NUM_PORT-1:0]    portMeta_r, portSync_r, portLatch_r;
  logic [NUM_PORT-1:0]    portLatch_nxt;
  logic [SYNC_STAGES-1:0] primed_r, primed_nxt;
  // One more cycle so the previous sample holds a real pin value too
  logic                   edgeArm_r, edgeArm_nxt;

  // Edge select one means rising, zero means falling
  always_comb begin
    // A pin idling high must not look like a rising edge after reset
    edgeArm_nxt = primed_r[SYNC_STAGES-1];
    ev.extEdge = edgeArm_r ?
                 ((extEdgeSelect & extSync_r & ~extPrev_r) |
                  (~extEdgeSelect & ~extSync_r & extPrev_r)) : '0;
    // Mismatch keeps asserting until a port read refreshes the latch
    ev.portChange = primed_r[SYNC_STAGES-1] && (portSync_r != portLatch_r);
    primed_nxt    = {primed_r[SYNC_STAGES-2:0], 1'b1};
    portLatch_nxt = (portRead || !primed_r[SYNC_STAGES-1]) ?
                    portSync_r : portLatch_r;
  end

  // Two flip-flops per pin before any logic looks at it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      extMeta_r   <= '0;
      extSync_r   <= '0;
      extPrev_r   <= '0;
      portMeta_r  <= '0;
      portSync_r  <= '0;
      portLatch_r <= '0;
      primed_r    <= '0;
      edgeArm_r   <= 1'b0;
    end else begin
      extMeta_r   <= extPin;
      extSync_r   <= extMeta_r;
      extPrev_r   <= extSync_r;
      portMeta_r  <= portPin;
      portSync_r  <= portMeta_r;
      portLatch_r <= portLatch_nxt;
      primed_r    <= primed_nxt;
      edgeArm_r   <= edgeArm_nxt;
    end
  end

  // ==========================================================
  // Assertions
  a_edge_select: assert property (@(posedge core_clk)
    disable iff (!resetn)
    ev.extEdge[0] |-> (extSync_r[0] == extEdgeSelect[0] &&
                       extPrev_r[0] != extSync_r[0]))
    else $error("edge event against its edge select");
endmodule // pin_event_detect
`default_nettype wire

// file: rtl/two_level_priority_interrupt_ctrl.sv
// Purpose: Two-level priority interrupt controller for an 8-bit core
// Assumes: Software-side bits arrive as plain ports on core_clk
// Notes:   Vector request is a one-cycle pulse with a registered address
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - High priority vectors to 0008h, low priority to 0018h.
// - Pending enabled high interrupt preempts a running low service routine.
// - Each source has a flag, an enable and a priority select.
// - Two-level mode is active only while the priority feature is enabled.
// - In priority mode the high global enable gates high sources.
// - In priority mode the low global enable gates low sources.
// - Flag, enable and global enable all set vector immediately by priority.
// - With priority feature off (reset default) priority bits are ignored.
// - Compatibility: bit 6 gates peripherals, bit 7 gates everything.
// - Compatibility mode always vectors to 0008h.
// - Accepting an interrupt clears the governing global enable.
// - No low interrupt is taken during a high service routine.
// - On vectoring the core pushes return address and loads the vector.
// - Return from service sets the global enable cleared on entry.
// - Pin and port change latency is three to four cycles, fixed.
// - Flags set on their event whatever the enables say.
// - High global enable clear disables all, set enables high sources.
// - Each edge pin has a select: one rising, zero falling.
module two_level_priority_interrupt_ctrl
  import intc_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic                priorityFeatureEnable,
  input  wire logic [NUM_EXT-1:0]  extPin,
  input  wire logic [NUM_EXT-1:0]  extEdgeSelect,
  input  wire logic [NUM_PORT-1:0] portPin,
  input  wire logic                portRead,
  input  wire logic [NUM_SRC-1:0]  sourceEvent,
  input  wire logic [NUM_SRC-1:0]  sourceEnable,
  input  wire logic [NUM_SRC-1:0]  sourcePriority,
  input  wire logic [NUM_SRC-1:0]  flagClear,
  input  wire logic                ctrlWrite,
  input  wire logic [7:0]          ctrlWdata,
  input  wire logic                returnFromIsr,
  output logic [NUM_SRC-1:0]       sourceFlags,
  output logic                     highGlobalEnable,
  output logic                     lowGlobalEnable,
  output logic                     inHighIsr,
  output logic                     inLowIsr,
  output logic                     vectorTake,
  output logic [15:0]              vectorAddr,
  output logic                     wakeRequest
);
  // ==========================================================
  // Pin event front end
  pin_event_if evBus ();

  pin_event_detect u_pin_event_detect (
    .core_clk      (core_clk),
    .resetn        (resetn),
    .extPin        (extPin),
    .extEdgeSelect (extEdgeSelect),
    .portPin       (portPin),
    .portRead      (portRead),
    .ev            (evBus.producer)
  );

  // ==========================================================
  // State declarations
  logic [NUM_SRC-1:0] flag_r, flag_nxt;
  logic [NUM_SRC-1:0] srcSet;
  logic               gieHigh_r, gieHigh_nxt;
  logic               gieLow_r, gieLow_nxt;
  isr_state_type      state_r, state_nxt;
  logic               take_r, take_nxt;
  logic [15:0]        vec_r, vec_nxt;
  logic               wake_r, wake_nxt;
  logic [NUM_SRC-1:0] armed;
  logic               prioMode;
  logic               highReq, lowReq, compatReq;
  logic               highBlocked;

  // ==========================================================
  // Flags: set wins over a clear in the same cycle
  always_comb begin
    srcSet = sourceEvent;
    srcSet[NUM_EXT-1:0] = sourceEvent[NUM_EXT-1:0] | evBus.extEdge;
    srcSet[SRC_PORT] = sourceEvent[SRC_PORT] | evBus.portChange;
    flag_nxt = (flag_r & ~flagClear) | srcSet;
  end

  // ==========================================================
  // Request qualification
  always_comb begin
    prioMode    = priorityFeatureEnable;
    armed       = flag_r & sourceEnable;
    highBlocked = (state_r == ST_HIGH) ||
                  (state_r == ST_HIGH_OVER_LOW);
    // High enable cleared disables everything in priority mode
    highReq = prioMode && gieHigh_r &&
              |(armed & sourcePriority);
    lowReq  = prioMode && gieHigh_r && gieLow_r && !highBlocked &&
              |(armed & ~sourcePriority);
    // Priority bits play no part when the feature is off
    compatReq = !prioMode && gieHigh_r &&
                |(armed & (~PERIPH_MASK |
                           {NUM_SRC{gieLow_r}}));
  end

  // ==========================================================
  // Acceptance, return and global enable control
  // A return in the same cycle defers acceptance by one cycle so that
  // the re-enabled bit is seen before a new context is entered.
  always_comb begin
    gieHigh_nxt = gieHigh_r;
    gieLow_nxt  = gieLow_r;
    state_nxt   = state_r;
    take_nxt    = 1'b0;
    vec_nxt     = vec_r;
    if (ctrlWrite) begin
      gieHigh_nxt = ctrlWdata[BIT_GIE_HIGH];
      gieLow_nxt  = ctrlWdata[BIT_GIE_LOW];
    end
    if (returnFromIsr) begin
      unique case (state_r)
        ST_HIGH: begin
          state_nxt   = ST_RUN;
          gieHigh_nxt = 1'b1;
        end
        ST_HIGH_OVER_LOW: begin
          state_nxt   = ST_LOW;
          gieHigh_nxt = 1'b1;
        end
        ST_LOW: begin
          state_nxt  = ST_RUN;
          gieLow_nxt = 1'b1;
        end
        ST_RUN: begin
          // Stray return from main line just restores the enable
          if (prioMode) begin
            gieLow_nxt = 1'b1;
          end else begin
            gieHigh_nxt = 1'b1;
          end
        end
      endcase
    end else if (highReq || compatReq) begin
      take_nxt    = 1'b1;
      vec_nxt     = VEC_HIGH;
      gieHigh_nxt = 1'b0;
      state_nxt   = (state_r == ST_LOW) ?
                    ST_HIGH_OVER_LOW : ST_HIGH;
    end else if (lowReq) begin
      take_nxt   = 1'b1;
      vec_nxt    = VEC_LOW;
      gieLow_nxt = 1'b0;
      state_nxt  = ST_LOW;
    end
    // Wake on any enabled pending source, globals not consulted
    wake_nxt = |armed;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flag_r    <= FLAG_RST;
      gieHigh_r <= GLOBAL_EN_RST;
      gieLow_r  <= GLOBAL_EN_RST;
      state_r   <= ST_RUN;
      take_r    <= 1'b0;
      vec_r     <= VEC_RST;
      wake_r    <= 1'b0;
    end else begin
      flag_r    <= flag_nxt;
      gieHigh_r <= gieHigh_nxt;
      gieLow_r  <= gieLow_nxt;
      state_r   <= state_nxt;
      take_r    <= take_nxt;
      vec_r     <= vec_nxt;
      wake_r    <= wake_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // Pin event to flag two to three cycles, flag to vector one more: latency is
  // set by sampling phase only, never by instruction length.
  assign sourceFlags      = flag_r;
  assign highGlobalEnable = gieHigh_r;
  assign lowGlobalEnable  = gieLow_r;
  assign inHighIsr        = highBlocked;
  assign inLowIsr         = (state_r == ST_LOW) ||
                            (state_r == ST_HIGH_OVER_LOW);
  assign vectorTake       = take_r;
  assign vectorAddr       = vec_r;
  assign wakeRequest      = wake_r;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_vec_level: assert property (take_r |->
    ((vec_r == VEC_LOW) == (state_r == ST_LOW)))
    else $error("vector address does not match entered level");
  a_compat_vec: assert property (
    (!prioMode && !returnFromIsr && compatReq) |=>
    (take_r && vec_r == VEC_HIGH))
    else $error("compatibility request did not vector to high");
  a_enable_clear: assert property ((take_r && vec_r == VEC_HIGH) |->
    !gieHigh_r)
    else $error("global enable not cleared on high entry");
  a_no_low_in_high: assert property (highBlocked |=>
    !(take_r && vec_r == VEC_LOW))
    else $error("low interrupt taken during high service");
  a_preempt: assert property (
    (state_r == ST_LOW && highReq && !returnFromIsr) |=>
    (take_r && vec_r == VEC_HIGH &&
     state_r == ST_HIGH_OVER_LOW))
    else $error("high request did not preempt low service");
  a_flag_set: assert property (srcSet[SRC_PORT] |=>
    flag_r[SRC_PORT])
    else $error("event did not set its flag");
  a_return_low: assert property (
    (returnFromIsr && state_r == ST_LOW && !ctrlWrite) |=>
    (gieLow_r && state_r == ST_RUN))
    else $error("return did not restore low enable");
  // An earlier request in the same cycle would legally use up the enable
  a_pin_latency: assert property (
    (evBus.extEdge[0] && sourceEnable[0] && !prioMode && gieHigh_r &&
     !compatReq && !flagClear[0] && !ctrlWrite && !returnFromIsr)
    ##1 !returnFromIsr |->
    ##1 (take_r && vec_r == VEC_HIGH))
    else $error("pin event latency not fixed");
  a_compat_no_low: assert property (!prioMode |=>
    !(take_r && vec_r == VEC_LOW))
    else $error("low vector used in compatibility mode");
  a_high_gate: assert property ((prioMode && !gieHigh_r) |=>
    !take_r)
    else $error("interrupt taken with high enable clear");
  a_low_gate: assert property (
    (prioMode && !gieLow_r && !highReq) |=> !take_r)
    else $error("low interrupt taken with low enable clear");
  a_high_needs: assert property (
    (prioMode && !(|(armed & sourcePriority)) && !lowReq) |=> !take_r)
    else $error("high vector without an armed high source");
  a_periph_gate: assert property (
    (!prioMode && !gieLow_r && !(|(armed & ~PERIPH_MASK))) |=> !take_r)
    else $error("peripheral taken with peripheral enable clear");
  a_flag_hold: assert property (
    (flag_r[5] && !flagClear[5]) |=> flag_r[5])
    else $error("flag lost without a clear");
  a_mode_gate: assert property ((prioMode && !gieHigh_r) |->
    !compatReq)
    else $error("compatibility request while priority mode on");
  a_wake: assert property ((|armed) |=> wake_r)
    else $error("wake request missing for armed source");

  c_high_entry: cover property (take_r && vec_r == VEC_HIGH);
  c_low_entry:  cover property (take_r && vec_r == VEC_LOW);
  c_nested:     cover property (state_r == ST_HIGH_OVER_LOW);
  c_return:     cover property (returnFromIsr && state_r == ST_LOW);
endmodule // two_level_priority_interrupt_ctrl
`default_nettype wire

// file: verif/core_seq_model.sv
// Purpose: Core sequencer and service software as seen by the controller
// Assumes: One core_clk domain, every pulse lasts one cycle
// Notes:   Services only on request, so the bench decides when to nest
`timescale 1ns/10ps
`default_nettype none
module core_seq_model (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        vectorTake,
  input  wire logic [15:0] vectorAddr,
  input  wire logic [7:0]  sourceFlags,
  input  wire logic        serviceReq,
  input  wire logic [7:0]  serviceMask,
  output logic [7:0]       flagClear,
  output logic             returnFromIsr,
  output logic [15:0]      pcValue,
  output logic [3:0]       stackDepth
);
  logic retPend;
  // ==========================================================
  // Stack and service sequence
  // Return waits one cycle so the flag clear lands first
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flagClear     <= 8'h00;
      returnFromIsr <= 1'b0;
      retPend       <= 1'b0;
      pcValue       <= 16'h0000;
      stackDepth    <= 4'h0;
    end else begin
      flagClear     <= 8'h00;
      returnFromIsr <= retPend;
      retPend       <= 1'b0;
      if (vectorTake) begin
        pcValue    <= vectorAddr;
        stackDepth <= stackDepth + 4'h1;
      end
      if (serviceReq) begin
        flagClear <= sourceFlags & serviceMask;
        retPend   <= 1'b1;
      end
      if (retPend) begin
        stackDepth <= stackDepth - 4'h1;
      end
    end
  end
endmodule // core_seq_model
`default_nettype wire

// file: verif/tb.sv
// Purpose: Self-checking bench of the two-level interrupt controller
// Assumes: Inputs change on the falling edge of core_clk
// Notes:   Each scenario starts from a fresh reset
`timescale 1ns/10ps
`default_nettype none
module tb;
  import intc_pkg::*;
  logic        core_clk = 1'b0;
  logic        resetn   = 1'b0;
  logic        prioEn   = 1'b0;
  logic [3:0]  extPin   = 4'h1;
  logic [3:0]  edgeSel  = 4'h0;
  logic [3:0]  portPin  = 4'h0;
  logic        portRead = 1'b0;
  logic [7:0]  srcEv    = 8'h00;
  logic [7:0]  srcEn    = 8'h00;
  logic [7:0]  srcPrio  = 8'h00;
  logic        ctrlWr   = 1'b0;
  logic [7:0]  ctrlData = 8'h00;
  logic        svcReq   = 1'b0;
  logic [7:0]  svcMask  = 8'h00;
  logic [7:0]  flags, flagClr;
  logic        hiEn, loEn, inHi, inLo, vTake, wake, retIsr;
  logic [15:0] vAddr, pcVal;
  logic [3:0]  depth;
  int          errCount = 0;
  int          nChecks  = 0;
  int          n;

  // ==========================================================
  // Clock, design and core model
  always #20 core_clk = ~core_clk;

  two_level_priority_interrupt_ctrl dut (
    .core_clk(core_clk), .resetn(resetn), .priorityFeatureEnable(prioEn),
    .extPin(extPin), .extEdgeSelect(edgeSel), .portPin(portPin),
    .portRead(portRead), .sourceEvent(srcEv), .sourceEnable(srcEn),
    .sourcePriority(srcPrio), .flagClear(flagClr), .ctrlWrite(ctrlWr),
    .ctrlWdata(ctrlData), .returnFromIsr(retIsr), .sourceFlags(flags),
    .highGlobalEnable(hiEn), .lowGlobalEnable(loEn), .inHighIsr(inHi),
    .inLowIsr(inLo), .vectorTake(vTake), .vectorAddr(vAddr),
    .wakeRequest(wake));

  core_seq_model core (
    .core_clk(core_clk), .resetn(resetn), .vectorTake(vTake),
    .vectorAddr(vAddr), .sourceFlags(flags), .serviceReq(svcReq),
    .serviceMask(svcMask), .flagClear(flagClr), .returnFromIsr(retIsr),
    .pcValue(pcVal), .stackDepth(depth));

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic doReset();
    resetn = 1'b0;
    cyc(12);
    resetn = 1'b1;
    cyc(3);
  endtask
  task automatic pulse(input logic [7:0] ev);
    srcEv = ev;
    cyc(1);
    srcEv = 8'h00;
  endtask
  // One plain write per call, never a memory move while enabled
  task automatic ctrl(input logic [7:0] d);
    ctrlWr   = 1'b1;
    ctrlData = d;
    cyc(1);
    ctrlWr   = 1'b0;
  endtask
  // Service by the core model; enable is back three cycles later
  task automatic serve(input logic [7:0] m);
    svcReq  = 1'b1;
    svcMask = m;
    cyc(1);
    svcReq  = 1'b0;
    cyc(4);
  endtask
  // Counts falling edges up to a vector pulse; limit+1 means none came
  task automatic waitTake(input int limit);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (vTake !== 1'b1 && n <= limit);
  endtask

  // ==========================================================
  // Scenarios
  task automatic testReset();
    doReset();
    chk({8'h00, flags}, 16'h0000);
    chk(vAddr, VEC_RST);
    chk({hiEn, loEn, inHi, inLo, vTake, wake}, 16'h0000);
    srcEn = 8'h04;
    pulse(8'h04);
    waitTake(5);
    chk(16'(n), 16'd6);
    chk({8'h00, flags}, 16'h0004);
    chk({15'h0, wake}, 16'h0001);
  endtask

  task automatic testCompat();
    doReset();
    srcEn   = 8'hff;
    srcPrio = 8'hff;
    ctrl(8'h80);
    pulse(8'h80);
    waitTake(5);
    chk(16'(n), 16'd6);
    chk({8'h00, flags}, 16'h0080);
    pulse(8'h20);
    waitTake(4);
    chk(16'(n), 16'd1);
    chk(vAddr, VEC_HIGH);
    chk({15'h0, hiEn}, 16'h0000);
    serve(8'hff);
    chk(pcVal, VEC_HIGH);
    chk({8'h00, flags}, 16'h0000);
    chk({15'h0, hiEn}, 16'h0001);
  endtask

  task automatic testPriority();
    doReset();
    prioEn  = 1'b1;
    srcEn   = 8'hff;
    srcPrio = 8'h40;
    ctrl(8'h40);
    pulse(8'h20);
    waitTake(5);
    chk(16'(n), 16'd6);
    ctrl(8'h80);
    waitTake(5);
    chk(16'(n), 16'd6);
    ctrl(8'hc0);
    waitTake(4);
    chk(16'(n), 16'd1);
    chk(vAddr, VEC_LOW);
    chk({hiEn, loEn, inLo}, 16'h0005);
    pulse(8'h40);
    waitTake(4);
    chk(16'(n), 16'd1);
    chk(vAddr, VEC_HIGH);
    chk({hiEn, inHi}, 16'h0001);
    cyc(1);
    chk({12'h0, depth}, 16'h0002);
    srcEn = 8'hbf;
    ctrl(8'hc0);
    waitTake(6);
    chk(16'(n), 16'd7);
  endtask

  task automatic testPin();
    edgeSel = 4'h4;
    doReset();
    prioEn  = 1'b1;
    srcEn   = 8'hff;
    srcPrio = 8'hff;
    ctrl(8'hc0);
    extPin[1] = 1'b1;
    waitTake(6);
    chk(16'(n), 16'd7);
    extPin[0] = 1'b0;
    waitTake(6);
    chk(16'(n >= 3 && n <= 4), 16'd1);
    serve(8'hff);
    chk({15'h0, hiEn}, 16'h0001);
    extPin[2] = 1'b1;
    waitTake(6);
    chk(16'(n >= 3 && n <= 4), 16'd1);
    // Port change: level keeps the flag up until the port is read
    serve(8'hff);
    portPin = 4'h1;
    waitTake(6);
    chk(16'(n >= 3 && n <= 4), 16'd1);
    chk({8'h00, flags}, 16'h0010);
    portRead = 1'b1;
    cyc(1);
    portRead = 1'b0;
    serve(8'hff);
    chk({8'h00, flags}, 16'h0000);
    chk({15'h0, hiEn}, 16'h0001);
  endtask

  // ==========================================================
  // Verdict, main sequence and watchdog
  task automatic finishTest();
    $display("checks=%0d errors=%0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    testReset();
    testCompat();
    testPriority();
    testPin();
    finishTest();
  end

  // Whole run is well under 400 cycles, so 2000 means a hang
  initial begin
    #(2000 * 40);
    errCount++;
    finishTest();
  end
endmodule // tb
`default_nettype wire
